// ### logic/lcp_host_port.sv
// Host port of a character display controller with data write buffer
`timescale 1ns/1ps
`default_nettype none

module lcp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             sys_rst,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    logic [AW:0]      next_wr_ptr;
    logic [AW:0]      next_rd_ptr;
    logic             push;
    logic             pop;

    always_comb begin
        in_ready    = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
        out_valid   = wr_ptr != rd_ptr;
        out_data    = mem[rd_ptr[AW-1:0]];
        push        = in_valid & in_ready;
        pop         = out_valid & out_ready;
        next_wr_ptr = wr_ptr + (AW+1)'(push);
        next_rd_ptr = rd_ptr + (AW+1)'(pop);
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
        end
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end
endmodule

module lcp_host_port #(
    parameter int OP_TIME_CYCLES = lcp_pkg::OP_CYCLES
) (
    // Clock and reset
    input  wire logic                        clock,
    input  wire logic                        sys_rst,
    // Host control pins
    input  wire logic                        register_select,
    input  wire logic                        read_write,
    input  wire logic                        enable_strobe,
    input  wire logic                        four_bit_mode,
    // Host data bus, split three ways
    input  wire logic [lcp_pkg::DATA_W-1:0]  host_data_bus_in,
    output logic [lcp_pkg::DATA_W-1:0]       host_data_bus_out,
    output logic                             host_data_bus_oe_n,
    // Status
    output logic                             busy_indication
);
    import lcp_pkg::*;

    logic [DATA_W-1:0] text_mem  [TEXT_DEPTH];
    logic [DATA_W-1:0] glyph_mem [GLYPH_DEPTH];

    // Two-flop synchronisers for every pin
    logic              rs_s1, rs_s2, rw_s1, rw_s2, en_s1, en_s2, en_d, four_s1, four_s2;
    logic [DATA_W-1:0] db_s1, db_s2;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            {rs_s1, rs_s2, rw_s1, rw_s2} <= 4'h0;
            {en_s1, en_s2, en_d, four_s1, four_s2} <= 5'h00;
            db_s1 <= 8'h00;
            db_s2 <= 8'h00;
        end else begin
            {rs_s1, rs_s2} <= {register_select, rs_s1};
            {rw_s1, rw_s2} <= {read_write, rw_s1};
            {en_s1, en_s2, en_d} <= {enable_strobe, en_s1, en_s2};
            {four_s1, four_s2} <= {four_bit_mode, four_s1};
            db_s1 <= host_data_bus_in;
            db_s2 <= db_s1;
        end
    end

    // Port state
    lcp_state_e        state, next_state;
    logic [15:0]       op_cnt, next_op_cnt;
    logic [DATA_W-1:0] command_register, next_command_register;
    logic [DATA_W-1:0] transfer_register, next_transfer_register;
    logic [PTR_W-1:0]  address_pointer, next_address_pointer;
    logic              sel_glyph, next_sel_glyph;
    logic              count_up, next_count_up;
    logic              nib_phase, next_nib_phase;
    logic [3:0]        wr_hi, next_wr_hi;
    logic [DATA_W-1:0] next_data_out;
    logic              next_oe_n;
    logic              next_busy;

    // Buffer and decode
    logic              en_fall, xfer_done, busy_now, cmd_take, data_wr, data_rd, status_rd;
    logic              fifo_in_ready, fifo_out_valid, fifo_pop, fifo_push;
    logic [DATA_W-1:0] fifo_out_data, wr_byte, read_byte, status_byte;
    logic [PTR_W-1:0]  ptr_step;

    function automatic logic [PTR_W-1:0] step_ptr(input logic [PTR_W-1:0] p,
                                                   input logic glyph, input logic up);
        logic [PTR_W-1:0] r;
        r = 7'h00;
        if (glyph) begin
            r = up ? ((p + 7'h01) & GLYPH_MASK) : ((p - 7'h01) & GLYPH_MASK);
        end else if (up) begin
            r = (p >= TEXT_LAST) ? 7'h00 : p + 7'h01;
        end else begin
            r = (p == 7'h00 || p > TEXT_LAST) ? TEXT_LAST : p - 7'h01;
        end
        return r;
    endfunction

    function automatic logic [DATA_W-1:0] mem_byte(input logic glyph, input logic [PTR_W-1:0] p);
        logic [DATA_W-1:0] r;
        r = 8'h00;
        if (glyph) begin
            r = glyph_mem[p[5:0]];
        end else if (p <= TEXT_LAST) begin
            r = text_mem[p];
        end
        return r;
    endfunction

    lcp_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_wr_fifo (
        .clock     (clock),
        .sys_rst   (sys_rst),
        .in_valid  (fifo_push),
        .in_ready  (fifo_in_ready),
        .in_data   (wr_byte),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_out_data)
    );

    always_comb begin
        en_fall   = en_d & ~en_s2; // RULE_17
        xfer_done = en_fall & (~four_s2 | nib_phase); // RULE_03
        wr_byte   = four_s2 ? {wr_hi, db_s2[7:4]} : db_s2;
        // Buffered writes count as busy so a command never overtakes data
        busy_now  = (state == LCP_EXEC) | fifo_out_valid;
        cmd_take  = xfer_done & ~rs_s2 & ~rw_s2 & ~busy_now; // RULE_05
        data_wr   = xfer_done & rs_s2 & ~rw_s2;
        data_rd   = xfer_done & rs_s2 & rw_s2;
        status_rd = ~rs_s2 & rw_s2;
        fifo_push = data_wr; // RULE_09
        // Drain stalls whenever a host transfer completes in the same cycle
        fifo_pop  = fifo_out_valid & (state == LCP_IDLE) & ~xfer_done;
        ptr_step  = step_ptr(address_pointer, sel_glyph, count_up); // RULE_13
        status_byte = {busy_now, address_pointer}; // RULE_04 RULE_07
        read_byte = status_rd ? status_byte : transfer_register; // RULE_01 RULE_08
    end

    always_comb begin
        next_state             = state;
        next_op_cnt            = op_cnt;
        next_command_register  = command_register;
        next_transfer_register = transfer_register;
        next_address_pointer   = address_pointer;
        next_sel_glyph         = sel_glyph;
        next_count_up          = count_up;
        next_nib_phase         = nib_phase;
        next_wr_hi             = wr_hi;
        if (en_fall && four_s2) begin
            next_nib_phase = ~nib_phase;
            if (!nib_phase) begin
                next_wr_hi = db_s2[7:4];
            end
        end
        if (!four_s2) begin
            next_nib_phase = 1'b0;
        end
        case (state)
            LCP_IDLE: begin
                if (cmd_take) begin
                    next_command_register = wr_byte;
                    next_state            = LCP_EXEC;
                    next_op_cnt           = 16'(OP_TIME_CYCLES);
                    if (wr_byte[CMD_TEXT_BIT]) begin
                        next_address_pointer   = wr_byte[6:0]; // RULE_12
                        next_sel_glyph         = 1'b0;
                        next_transfer_register = mem_byte(1'b0, wr_byte[6:0]); // RULE_10
                    end else if (wr_byte[CMD_GLYPH_BIT]) begin
                        next_address_pointer   = {1'b0, wr_byte[5:0]}; // RULE_12
                        next_sel_glyph         = 1'b1;
                        next_transfer_register = mem_byte(1'b1, {1'b0, wr_byte[5:0]}); // RULE_10
                    end else if (wr_byte[7:2] == CMD_ENTRY_TAG) begin
                        next_count_up = wr_byte[ENTRY_INC_BIT];
                    end
                end else if (fifo_pop) begin
                    next_transfer_register = fifo_out_data;
                    next_address_pointer   = ptr_step; // RULE_13
                    next_state             = LCP_EXEC;
                    next_op_cnt            = 16'(OP_TIME_CYCLES);
                end
            end
            LCP_EXEC: begin
                if (op_cnt <= 16'h0001) begin
                    next_state  = LCP_IDLE;
                    next_op_cnt = 16'h0000;
                end else begin
                    next_op_cnt = op_cnt - 16'h0001;
                end
            end
            default: begin
                next_state  = LCP_IDLE;
                next_op_cnt = 16'h0000;
            end
        endcase
        if (data_rd) begin
            next_address_pointer   = ptr_step; // RULE_11
            next_transfer_register = mem_byte(sel_glyph, ptr_step); // RULE_16
        end
        next_oe_n     = ~(en_s2 & rw_s2); // RULE_02 RULE_17
        next_data_out = read_byte;
        if (four_s2) begin
            next_data_out = {(nib_phase ? read_byte[3:0] : read_byte[7:4]), 4'h0}; // RULE_03
        end
        next_busy = (next_state == LCP_EXEC) | fifo_out_valid;
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state              <= LCP_IDLE;
            op_cnt             <= 16'h0000;
            command_register   <= 8'h00;
            transfer_register  <= 8'h00;
            address_pointer    <= 7'h00;
            sel_glyph          <= 1'b0;
            count_up           <= ENTRY_RESET;
            nib_phase          <= 1'b0;
            wr_hi              <= 4'h0;
            host_data_bus_out  <= 8'h00;
            host_data_bus_oe_n <= 1'b1;
            busy_indication    <= 1'b0;
        end else begin
            state              <= next_state;
            op_cnt             <= next_op_cnt;
            command_register   <= next_command_register;
            transfer_register  <= next_transfer_register;
            address_pointer    <= next_address_pointer;
            sel_glyph          <= next_sel_glyph;
            count_up           <= next_count_up;
            nib_phase          <= next_nib_phase;
            wr_hi              <= next_wr_hi;
            host_data_bus_out  <= next_data_out;
            host_data_bus_oe_n <= next_oe_n;
            busy_indication    <= next_busy;
        end
    end

    // Memory write at the pointer when a buffered byte is drained
    always_ff @(posedge clock) begin
        if (fifo_pop && sel_glyph) begin
            glyph_mem[address_pointer[5:0]] <= fifo_out_data; // RULE_15
        end
        if (fifo_pop && !sel_glyph && address_pointer <= TEXT_LAST) begin
            text_mem[address_pointer] <= fifo_out_data; // RULE_14 RULE_09
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    sequence seq_status_read;
        en_s2 & rw_s2 & ~rs_s2 & ~four_s2;
    endsequence

    sequence seq_data_read_done;
        data_rd;
    endsequence

    a_status_drive: assert property (seq_status_read |=> // RULE_04 RULE_07
        host_data_bus_out == $past(status_byte) && !host_data_bus_oe_n)
        else $error("status read drove wrong byte");
    a_busy_ignore: assert property (xfer_done & ~rs_s2 & ~rw_s2 & busy_now |=> // RULE_05
        $stable(command_register))
        else $error("command taken while busy");
    a_write_float: assert property (!rw_s2 |=> host_data_bus_oe_n) // RULE_02
        else $error("bus driven during host write");
    a_text_addr: assert property (cmd_take & wr_byte[7] |=> // RULE_10 RULE_12
        address_pointer == $past(wr_byte[6:0]) && !sel_glyph && busy_indication)
        else $error("text address command not applied");
    a_read_step: assert property (seq_data_read_done |=> // RULE_11 RULE_13
        address_pointer == $past(ptr_step))
        else $error("pointer did not step after data read");
    a_nibble_low: assert property (four_s2 & en_s2 & rw_s2 |=> // RULE_03
        host_data_bus_out[3:0] == 4'h0)
        else $error("low lines used in 4-bit mode");
    a_ptr_range: assert property (!sel_glyph |-> address_pointer <= TEXT_LAST) // RULE_14
        else $error("text pointer out of range");
    a_exec_hold: assert property (cmd_take |=> busy_indication [*2]) // RULE_05
        else $error("busy dropped too soon");
    a_glyph_range: assert property (sel_glyph |-> address_pointer[6] == 1'b0) // RULE_15
        else $error("glyph pointer out of range");
endmodule

`default_nettype wire

// ### logic/lcp_pkg.sv
// Constants for the character display controller host port
//
// Notes on behaviour
// [RULE_01] Select low: write command, read status; select high: data register both ways.
// [RULE_02] Direction low means host writes, high means host reads.
// [RULE_03] In 4-bit mode only the upper four data lines carry nibbles.
// [RULE_04] Status read drives the busy indication on the top data line.
// [RULE_05] While busy, further command writes are ignored.
// [RULE_06] Host polls status and waits for busy low before next command.
// [RULE_07] Status read drives the address pointer on the seven low lines.
// [RULE_08] Command register is write only, never returned on a read.
// [RULE_09] Written data moves by itself into the selected memory at the pointer; a write that meets a full 16-entry buffer is dropped and never stored.
// [RULE_10] An address command prefetches the addressed byte into the transfer register.
// [RULE_11] After a data read the next address byte is loaded for the next read.
// [RULE_12] Address command loads the pointer and selects text or glyph memory.
// [RULE_13] Each data write or read steps the pointer by one, up or down; a write dropped at a full write buffer does not step it.
// [RULE_14] Text memory holds 80 bytes.
// [RULE_15] Glyph memory holds 64 rewritable bytes.
// [RULE_16] A data read cycle triggers transfer of the next byte into the register.
// [RULE_17] Strobe high drives read data; write data is captured on its falling edge.
package lcp_pkg;
    localparam int          DATA_W        = 8;
    localparam int          PTR_W         = 7;
    localparam int          TEXT_DEPTH    = 80;
    localparam int          GLYPH_DEPTH   = 64;
    localparam int          FIFO_DEPTH    = 16;
    localparam int          OP_CYCLES     = 10;
    localparam int          BUSY_BIT      = 7;
    localparam int          CMD_TEXT_BIT  = 7;
    localparam int          CMD_GLYPH_BIT = 6;
    localparam int          ENTRY_INC_BIT = 1;
    localparam logic [5:0]  CMD_ENTRY_TAG = 6'h01;
    localparam logic [6:0]  TEXT_LAST     = 7'h4F;
    localparam logic [6:0]  GLYPH_MASK    = 7'h3F;
    localparam logic        ENTRY_RESET   = 1'b1;
    localparam logic [15:0] OP_CNT_W_MAX  = 16'hFFFF;

    typedef enum logic [1:0] {
        LCP_IDLE = 2'b01,
        LCP_EXEC = 2'b10
    } lcp_state_e;
endpackage

// ### testbench/lcp_host_model.sv
// Host processor model driving the controller's bus pins
`timescale 1ns/1ps
`default_nettype none

module lcp_host_model (
    // Clock and bus width
    input  wire logic       clock,
    input  wire logic       four_bit,
    // Pins toward the device
    output logic            register_select,
    output logic            read_write,
    output logic            enable_strobe,
    output logic            drv_en,
    output logic [7:0]      drv_data,
    // Bus level seen at the pins
    input  wire logic [7:0] bus_level
);
    initial begin
        register_select = 1'b0;
        read_write      = 1'b0;
        enable_strobe   = 1'b0;
        drv_en          = 1'b0;
        drv_data        = 8'h00;
    end

    // Control and data held four edges past the strobe fall
    task automatic strobe(input logic rs, input logic rw, input logic [7:0] wd,
                          output logic [7:0] rd);
        @(negedge clock);
        register_select = rs;
        read_write      = rw;
        drv_en          = !rw;
        drv_data        = wd;
        @(negedge clock);
        enable_strobe = 1'b1;
        repeat (6) @(negedge clock);
        rd            = bus_level;
        enable_strobe = 1'b0;
        repeat (4) @(negedge clock);
        drv_en = 1'b0;
    endtask

    // Low lines carry junk in 4-bit mode, so a device using them is caught
    task automatic xfer(input logic rs, input logic rw, input logic [7:0] wd,
                        output logic [7:0] rd);
        logic [7:0] hi;
        logic [7:0] lo;
        if (four_bit) begin
            strobe(rs, rw, {wd[7:4], ~wd[7:4]}, hi);
            strobe(rs, rw, {wd[3:0], ~wd[3:0]}, lo);
            rd = {hi[7:4], lo[7:4]};
        end else begin
            strobe(rs, rw, wd, rd);
        end
    endtask

    task automatic wait_idle(output logic [7:0] st);
        int polls;
        polls = 0;
        do begin
            xfer(1'b0, 1'b1, 8'h00, st);
            polls++;
        end while (st[7] !== 1'b0 && polls < 1000);
    endtask
endmodule

`default_nettype wire

// ### testbench/test_lcp_host_port.sv
// Self-checking bench for the display controller host port
`timescale 1ns/1ps
`default_nettype none

module test_lcp_host_port;
    import lcp_pkg::*;
    // Long operation time lets the write buffer fill before it drains
    localparam int OPT = 250;
    logic       clock         = 1'b0;
    logic       sys_rst       = 1'b1;
    logic       four_bit_mode = 1'b0;
    logic       rs;
    logic       rw;
    logic       en;
    logic       h_en;
    logic       oe_n;
    logic       busy;
    logic       g             = 1'b0;
    logic       up            = 1'b1;
    logic [6:0] ptr           = 7'h00;
    logic [7:0] h_dat;
    logic [7:0] bus_out;
    logic [7:0] bus_in;
    logic [7:0] last          = 8'h00;
    logic [7:0] rd;
    logic [7:0] txt [0:79];
    logic [7:0] gly [0:63];
    int         fails         = 0;
    int         checks_done   = 0;
    int         seed;

    // Released bus shows the inverse of its last level
    assign bus_in = !oe_n ? bus_out : (h_en ? h_dat : ~last);
    always @(posedge clock) last <= bus_in;

    initial begin
        forever #2 clock = ~clock;
    end

    lcp_host_port #(.OP_TIME_CYCLES(OPT)) DUT (
        .clock(clock), .sys_rst(sys_rst), .register_select(rs), .read_write(rw),
        .enable_strobe(en), .four_bit_mode(four_bit_mode), .host_data_bus_in(bus_in),
        .host_data_bus_out(bus_out), .host_data_bus_oe_n(oe_n), .busy_indication(busy));

    lcp_host_model host (
        .clock(clock), .four_bit(four_bit_mode), .register_select(rs), .read_write(rw),
        .enable_strobe(en), .drv_en(h_en), .drv_data(h_dat), .bus_level(bus_in));

    task automatic stop_test();
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    function automatic logic [6:0] step(input logic [6:0] p);
        if (g) return up ? {1'b0, p[5:0] + 6'h01} : {1'b0, p[5:0] - 6'h01};
        if (up) return (p == TEXT_LAST) ? 7'h00 : p + 7'h01;
        return (p == 7'h00) ? TEXT_LAST : p - 7'h01;
    endfunction

    // Buffered data may still be draining, so every command polls first
    task automatic cmd(input logic [7:0] c);
        host.wait_idle(rd);
        host.xfer(1'b0, 1'b0, c, rd);
        check({7'h00, busy}, 8'h01, "busy pin after command");
        host.xfer(1'b0, 1'b1, 8'h00, rd);
        check({7'h00, rd[7]}, 8'h01, "busy after command");
        host.wait_idle(rd);
        check({7'h00, busy}, 8'h00, "busy pin after idle");
    endtask

    task automatic setadr(input logic glyph, input logic [6:0] a);
        cmd(glyph ? {2'b01, a[5:0]} : {1'b1, a});
        g   = glyph;
        ptr = glyph ? {1'b0, a[5:0]} : a;
        check(rd, {1'b0, ptr}, "pointer after address");
    endtask

    task automatic wr(input logic [7:0] d);
        host.xfer(1'b1, 1'b0, d, rd);
        if (g) gly[ptr[5:0]] = d;
        else txt[ptr] = d;
        ptr = step(ptr);
    endtask

    task automatic rdd();
        host.xfer(1'b1, 1'b1, 8'h00, rd);
        check(rd, g ? gly[ptr[5:0]] : txt[ptr], "data read");
        check({7'h00, oe_n}, 8'h01, "bus released");
        ptr = step(ptr);
    endtask

    initial begin
        repeat (60000) @(posedge clock);
        fails++;
        $display("BAD %0t run did not finish", $time);
        stop_test();
    end

    initial begin
        seed = $urandom(79542);
        repeat (5) @(posedge clock);
        @(negedge clock) sys_rst = 1'b0;
        repeat (3) @(negedge clock);
        host.wait_idle(rd);
        check(rd, 8'h00, "status after reset");
        // Fill across the text wrap; the eighteenth write meets a full buffer
        setadr(1'b0, 7'd70);
        for (int i = 0; i < 17; i++) wr(8'($urandom));
        host.xfer(1'b1, 1'b0, 8'($urandom), rd);
        host.wait_idle(rd);
        check(rd, {1'b0, ptr}, "pointer after fill");
        setadr(1'b0, 7'd70);
        for (int i = 0; i < 17; i++) rdd();
        // Second command lands while busy and must vanish
        host.xfer(1'b0, 1'b0, 8'h85, rd);
        host.xfer(1'b0, 1'b0, 8'hA8, rd);
        host.wait_idle(rd);
        check(rd, 8'h05, "command while busy");
        ptr = 7'd5;
        rdd();
        // Glyph memory, counting down and then up through the 6-bit wrap
        up = 1'b0;
        cmd(8'h04);
        setadr(1'b1, 7'd1);
        for (int i = 0; i < 3; i++) wr(8'($urandom));
        host.wait_idle(rd);
        check(rd, {1'b0, ptr}, "glyph pointer down");
        up = 1'b1;
        cmd(8'h06);
        setadr(1'b1, 7'd63);
        for (int i = 0; i < 3; i++) rdd();
        // Nibble transfers on the upper lines
        @(negedge clock) four_bit_mode = 1'b1;
        repeat (4) @(negedge clock);
        setadr(1'b0, 7'd79);
        for (int i = 0; i < 2; i++) wr(8'($urandom));
        setadr(1'b0, 7'd79);
        for (int i = 0; i < 2; i++) rdd();
        host.wait_idle(rd);
        check(rd, {1'b0, ptr}, "pointer in nibble mode");
        @(negedge clock) four_bit_mode = 1'b0;
        stop_test();
    end
endmodule

`default_nettype wire
